/* hw/config_mode_register_access.sv */
// Keyed configuration mode with index and data ports for sixteen configuration registers
//
// What this block and its host do
// [R1] Two back-to-back 55H writes to 3F0H unlock
// [R2] Any other write between keys aborts unlock
// [R3] Host masks interrupts during the key pair
// [R4] In mode, 3F0H write loads index 0-F
// [R5] In mode, 3F1H accesses the selected register
// [R6] AAH written to 3F0H leaves the mode
// [R7] Index must be loaded before data access
// [R8] Registers default at power-up, not on reset
// [R9] Second variant uses key 44H instead
// [R10] Outside mode, ports change no register state
// [R11] Identity read-only; reserved and test ignore writes
`timescale 1ns/1ps
`include "cfg_defs.svh"

module config_mode_register_access #(
  parameter bit         ALT_KEY_VARIANT = 1'b0,
  parameter logic [7:0] ID_CODE         = 8'h5A, // Arbitrary value
  parameter logic [7:0] REV_CODE        = 8'h03  // Arbitrary value
) (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  // Host I/O cycle, one-cycle strobes
  input  wire logic [9:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  // Read answer
  output logic [7:0]       io_rdata,
  output logic             io_rdata_valid,
  output logic             io_claim,
  // Mode and register contents
  output logic             config_mode,
  output logic [11:0][7:0] configuration_registers
);

  localparam logic [7:0] UNLOCK_KEY = ALT_KEY_VARIANT ? `CFG_KEY_ALT : `CFG_KEY_MAIN;

  // Power-up image of the stored registers, slot 0 in the low byte
  localparam logic [11:0][7:0] CFG_DEFAULTS = {
    `CFG_RST_B, `CFG_RST_A, `CFG_RST_9, `CFG_RST_8,
    `CFG_RST_7, `CFG_RST_6, `CFG_RST_5, `CFG_RST_4,
    `CFG_RST_3, `CFG_RST_2, `CFG_RST_1, `CFG_RST_0
  };

  // Full address compare, shared by both port decoders
  function automatic logic is_port(input logic [9:0] addr, input logic [9:0] port);
    is_port = (addr == port);
  endfunction

  // Read mux over stored, identity and reserved slots
  function automatic logic [7:0] read_value(input logic [3:0] idx,
                                            input logic [11:0][7:0] r);
    logic [7:0] v;
    v = `CFG_RSVD_READ;
    case (idx)
      `CFG_IDX_RSVD_B: v = `CFG_RSVD_READ;
      `CFG_IDX_RSVD_C: v = `CFG_RSVD_READ;
      `CFG_IDX_ID:     v = ID_CODE;
      `CFG_IDX_REV:    v = REV_CODE;
      `CFG_IDX_TEST:   v = `CFG_RSVD_READ;
      default:         v = r[idx];
    endcase
    read_value = v;
  endfunction

  cfg_pkg::ctl_s c;
  cfg_pkg::ctl_s next_c;
  cfg_pkg::cfg_s f;
  cfg_pkg::cfg_s next_f;

  logic                          hit_idx;
  logic                          hit_dat;
  logic                          enter;
  logic                          cfg_wr;
  logic [`CFG_NUM_STORED-1:0]    wr_en;

  // Port decode
  assign hit_idx = is_port(io_addr, `CFG_PORT_INDEX);
  assign hit_dat = is_port(io_addr, `CFG_PORT_DATA);

  // Key sequence lives apart so it can watch every host write
  cfg_key_detect #(
    .KEY      (UNLOCK_KEY) // R9
  ) u_key (
    .clk      (clk),
    .rst_n    (rst_n),
    .io_wr    (io_wr),
    .io_addr  (io_addr),
    .io_wdata (io_wdata),
    .in_cfg   (config_mode),
    .enter    (enter)
  );

  // Data port write, only with a loaded index inside the mode
  assign cfg_wr = (c.mode == cfg_pkg::MODE_IN) && io_wr && hit_dat && c.idx_valid; // R5 R7

  // One write enable per stored slot; reserved slot B keeps its power-up value
  genvar g;
  generate
    for (g = 0; g < `CFG_NUM_STORED; g++) begin : gen_wr_en
      assign wr_en[g] = cfg_wr && (c.idx == 4'(g)) && (4'(g) != `CFG_IDX_RSVD_B); // R11
    end
  endgenerate

  // Mode, index and read answer
  always_comb begin
    next_c        = c;
    next_c.rvalid = 1'b0;
    case (c.mode)
      cfg_pkg::MODE_OUT: begin
        if (enter) begin
          next_c.mode      = cfg_pkg::MODE_IN; // R1
          next_c.idx_valid = 1'b0;             // R7
        end
      end
      cfg_pkg::MODE_IN: begin
        if (io_wr && hit_idx) begin
          if (io_wdata == `CFG_EXIT_KEY) begin
            next_c.mode      = cfg_pkg::MODE_OUT; // R6
            next_c.idx_valid = 1'b0;
          end else if (io_wdata[`CFG_IDX_HI_MSB:`CFG_IDX_HI_LSB] == 4'h0) begin
            next_c.idx       = io_wdata[`CFG_IDX_MSB:0]; // R4
            next_c.idx_valid = 1'b1;
          end
        end else if (io_rd && hit_dat && c.idx_valid) begin
          next_c.rdata  = read_value(c.idx, f.r); // R5
          next_c.rvalid = 1'b1;
        end
      end
      default: begin
        next_c.mode = cfg_pkg::MODE_OUT;
      end
    endcase
  end

  // Stored registers; identity, reserved slot C and test slots hold nothing, reserved slot B only its power-up value
  always_comb begin
    next_f = f;
    for (int i = 0; i < `CFG_NUM_STORED; i++) begin
      if (wr_en[i]) begin
        next_f.r[i] = io_wdata; // R5
      end
    end
  end

  // Ordinary reset drops the mode, index and read answer only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c <= '{mode: cfg_pkg::MODE_OUT, idx_valid: 1'b0, idx: 4'h0,
             rdata: 8'h00, rvalid: 1'b0};
    end else begin
      c <= next_c;
    end
  end

  // Power-up only: contents must survive an ordinary reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      f.r <= CFG_DEFAULTS; // R8
    end else begin
      f <= next_f;
    end
  end

  // Outputs; claim tells the other decoders to keep off this cycle
  assign config_mode             = (c.mode == cfg_pkg::MODE_IN);
  assign io_rdata                = c.rdata;
  assign io_rdata_valid          = c.rvalid;
  assign io_claim                = config_mode && (hit_idx || hit_dat) && (io_wr || io_rd); // R10
  assign configuration_registers = f.r;

  // Checks on the mode sequence and register access
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !por_n);

  sequence key_wr;
    io_wr && hit_idx && io_wdata == UNLOCK_KEY && !config_mode;
  endsequence

  sequence other_wr;
    io_wr && !(hit_idx && io_wdata == UNLOCK_KEY) && !config_mode;
  endsequence

  chk_enter_pair: assert property ( // R1
    key_wr ##1 key_wr |=> config_mode)
    else $error("Two key writes did not unlock");

  chk_enter_cause: assert property ( // R9
    $rose(config_mode) |-> $past(io_wr && hit_idx && io_wdata == UNLOCK_KEY))
    else $error("Mode entered without a key write");

  chk_abort_between: assert property ( // R2
    key_wr ##1 !io_wr ##1 other_wr ##1 !io_wr ##1 key_wr |=> !config_mode)
    else $error("Interrupted key pair still unlocked");

  chk_index_load: assert property ( // R4
    config_mode && io_wr && hit_idx && io_wdata[7:4] == 4'h0
    |=> c.idx_valid && c.idx == $past(io_wdata[3:0]))
    else $error("Index not loaded from port write");

  chk_data_read: assert property ( // R5
    config_mode && io_rd && hit_dat && c.idx_valid && c.idx == 4'h0 && !io_wr
    |=> io_rdata_valid && io_rdata == $past(configuration_registers[0]))
    else $error("Data port read returned wrong value");

  chk_data_write: assert property ( // R5
    config_mode && io_wr && hit_dat && c.idx_valid && c.idx == 4'h2
    |=> configuration_registers[2] == $past(io_wdata))
    else $error("Data port write not stored");

  chk_exit_key: assert property ( // R6
    config_mode && io_wr && hit_idx && io_wdata == `CFG_EXIT_KEY
    |=> !config_mode ##1 !config_mode)
    else $error("Exit key did not leave the mode");

  chk_index_first: assert property ( // R7
    $rose(config_mode) |-> !c.idx_valid)
    else $error("Index valid straight after entry");

  chk_no_index_read: assert property ( // R7
    config_mode && !c.idx_valid && io_rd && hit_dat |=> !io_rdata_valid)
    else $error("Data read answered without index");

  chk_keep_on_reset: assert property ( // R8
    @(posedge clk) disable iff (!por_n)
    !rst_n |=> $stable(configuration_registers))
    else $error("Ordinary reset altered registers");

  chk_outside_quiet: assert property ( // R10
    !config_mode |=> $stable(configuration_registers) && $stable(c.idx))
    else $error("Register state changed outside mode");

  chk_id_fixed: assert property ( // R11
    config_mode && io_rd && hit_dat && c.idx_valid && c.idx == `CFG_IDX_ID && !io_wr
    |=> io_rdata == ID_CODE)
    else $error("Identity read returned wrong value");

  chk_ro_ignore: assert property ( // R11
    config_mode && io_wr && hit_dat && c.idx >= 4'hB
    |=> $stable(configuration_registers))
    else $error("Read-only slot took a write");

  // Refusals: stray writes, out-of-range index, access without index
  chk_single_other: assert property ( // R2
    other_wr |=> !config_mode)
    else $error("Mode entered on a non-key write");

  chk_mode_hold: assert property ( // R6
    config_mode && !(io_wr && hit_idx && io_wdata == `CFG_EXIT_KEY) |=> config_mode)
    else $error("Mode left without the exit key");

  chk_index_ignore: assert property ( // R4
    config_mode && io_wr && hit_idx && io_wdata[7:4] != 4'h0 && io_wdata != `CFG_EXIT_KEY
    |=> $stable(c.idx) && $stable(c.idx_valid))
    else $error("Out-of-range index was taken");

  chk_exit_index: assert property ( // R7
    config_mode && io_wr && hit_idx && io_wdata == `CFG_EXIT_KEY |=> !c.idx_valid)
    else $error("Index still valid after exit");

  chk_no_index_write: assert property ( // R7
    config_mode && !c.idx_valid && io_wr && hit_dat |=> $stable(configuration_registers))
    else $error("Data write landed without index");

  chk_wr_outside: assert property ( // R10
    !config_mode && io_wr && hit_dat |=> $stable(configuration_registers))
    else $error("Data write landed outside the mode");

  chk_read_outside: assert property ( // R10
    !config_mode && io_rd |=> !io_rdata_valid)
    else $error("Read answered outside the mode");

  // Read answers: data stands until the next answer
  chk_rdata_hold: assert property ( // R5
    $changed(io_rdata) |-> io_rdata_valid)
    else $error("Read data moved without an answer");

  chk_rvalid_cause: assert property ( // R5
    io_rdata_valid |-> $past(io_rd && hit_dat && config_mode))
    else $error("Read answer without a data-port read");

  chk_rsvd_read: assert property ( // R11
    config_mode && io_rd && hit_dat && c.idx_valid && c.idx == `CFG_IDX_RSVD_B && !io_wr
    |=> io_rdata == `CFG_RSVD_READ)
    else $error("Reserved read returned wrong value");

  chk_rev_fixed: assert property ( // R11
    config_mode && io_rd && hit_dat && c.idx_valid && c.idx == `CFG_IDX_REV && !io_wr
    |=> io_rdata == REV_CODE)
    else $error("Revision read returned wrong value");

  cov_enter:   cover property ($rose(config_mode));
  cov_exit:    cover property ($fell(config_mode));
  cov_write:   cover property (cfg_wr && c.idx == 4'h2);
  cov_id_read: cover property (io_rdata_valid && c.idx == `CFG_IDX_ID);
  cov_abort:   cover property (key_wr ##1 !io_wr ##1 other_wr);

endmodule

/* hw/cfg_defs.svh */
// Port addresses, key values, field positions and power-up defaults of the configuration block
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH

// Host I/O ports, full ten-bit decode
`define CFG_PORT_INDEX   10'h3F0
`define CFG_PORT_DATA    10'h3F1

// Key and exit values written to the index port
`define CFG_KEY_MAIN     8'h55
`define CFG_KEY_ALT      8'h44
`define CFG_EXIT_KEY     8'hAA

// Index field: only values 00-0F select a register
`define CFG_IDX_HI_MSB   7
`define CFG_IDX_HI_LSB   4
`define CFG_IDX_MSB      3

// Register slots
`define CFG_NUM_STORED   12
`define CFG_IDX_RSVD_B   4'hB
`define CFG_IDX_RSVD_C   4'hC
`define CFG_IDX_ID       4'hD
`define CFG_IDX_REV      4'hE
`define CFG_IDX_TEST     4'hF

// Power-up defaults of the stored registers, slot 0 to slot B
`define CFG_RST_0        8'h3B
`define CFG_RST_1        8'h9F
`define CFG_RST_2        8'hDC
`define CFG_RST_3        8'h78
`define CFG_RST_4        8'h00
`define CFG_RST_5        8'h00
`define CFG_RST_6        8'hFF
`define CFG_RST_7        8'h00
`define CFG_RST_8        8'h00
`define CFG_RST_9        8'h00
`define CFG_RST_A        8'h00
`define CFG_RST_B        8'h00

// Read value of reserved and test slots
`define CFG_RSVD_READ    8'h00

`endif

/* hw/cfg_pkg.sv */
// Types shared by the configuration access logic
package cfg_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [0:0] {
    KEY_IDLE  = 1'b0,
    KEY_ARMED = 1'b1
  } key_state_e;

  typedef enum logic [0:0] {
    MODE_OUT = 1'b0,
    MODE_IN  = 1'b1
  } mode_e;

  typedef struct packed {
    key_state_e st;
  } key_s;

  typedef struct packed {
    mode_e      mode;
    logic       idx_valid;
    logic [3:0] idx;
    byte_t      rdata;
    logic       rvalid;
  } ctl_s;

  typedef struct packed {
    logic [11:0][7:0] r;
  } cfg_s;

endpackage

/* hw/cfg_key_detect.sv */
// Detector for the two back-to-back key writes that unlock configuration mode
`timescale 1ns/1ps
`include "cfg_defs.svh"

module cfg_key_detect #(
  parameter logic [7:0] KEY = `CFG_KEY_MAIN
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Host write strobe
  input  wire logic       io_wr,
  input  wire logic [9:0] io_addr,
  input  wire logic [7:0] io_wdata,
  // Mode status and unlock pulse
  input  wire logic       in_cfg,
  output logic            enter
);

  cfg_pkg::key_s s;
  cfg_pkg::key_s next_s;

  // First key arms, second key unlocks, anything else written disarms
  always_comb begin
    next_s = s;
    enter  = 1'b0;
    if (in_cfg) begin
      next_s.st = cfg_pkg::KEY_IDLE;
    end else if (io_wr) begin
      if (io_addr == `CFG_PORT_INDEX && io_wdata == KEY) begin
        case (s.st)
          cfg_pkg::KEY_IDLE: begin
            next_s.st = cfg_pkg::KEY_ARMED;
          end
          cfg_pkg::KEY_ARMED: begin
            enter     = 1'b1; // R1
            next_s.st = cfg_pkg::KEY_IDLE;
          end
          default: begin
            next_s.st = cfg_pkg::KEY_IDLE;
          end
        endcase
      end else begin
        next_s.st = cfg_pkg::KEY_IDLE; // R2
      end
    end
  end

  // Reads leave the arming alone; only writes break the pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: cfg_pkg::KEY_IDLE};
    end else begin
      s <= next_s;
    end
  end

endmodule

/* tb/io_host.sv */
// Host model issuing single-cycle I/O port cycles to the configuration block
`timescale 1ns/1ps
`include "cfg_defs.svh"

module io_host (
  // Clock
  input  wire logic       clk,
  // Read answer
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rdata_valid,
  // Host cycle
  output logic [9:0]      io_addr,
  output logic [7:0]      io_wdata,
  output logic            io_wr,
  output logic            io_rd
);
  // Idle bus at time zero
  initial begin
    io_addr  = 10'h000;
    io_wdata = 8'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  end

  // Released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge clk);
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask

  // Answer is sampled half a cycle after the taking edge
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clk);
    io_rd   = 1'b0;
    io_addr = ~a;
    d       = io_rdata;
    v       = io_rdata_valid;
  endtask

  // Key pair on two back-to-back edges; caller keeps interrupts out
  task automatic unlock(input logic [7:0] key);
    @(negedge clk);
    io_addr  = `CFG_PORT_INDEX;
    io_wdata = key;
    io_wr    = 1'b1;
    repeat (2) @(negedge clk);
    io_wr    = 1'b0;
    io_addr  = ~`CFG_PORT_INDEX;
    io_wdata = ~key;
  endtask

  // Index is loaded before each ordinary data-port access
  task automatic sel(input logic [3:0] i);
    wr(`CFG_PORT_INDEX, {4'h0, i});
  endtask

  // Exit key
  task automatic leave();
    wr(`CFG_PORT_INDEX, `CFG_EXIT_KEY);
  endtask
endmodule

/* tb/config_mode_register_access_tb_top.sv */
// Self-checking bench for the keyed configuration access block
`timescale 1ns/1ps
`include "cfg_defs.svh"

module config_mode_register_access_tb_top;
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_s;

  localparam logic [7:0] ID  = 8'h5A; // Arbitrary value
  localparam logic [7:0] REV = 8'h03; // Arbitrary value

  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             por_n = 1'b0;
  logic [9:0]       io_addr;
  logic [7:0]       io_wdata;
  logic             io_wr;
  logic             io_rd;
  logic [7:0]       io_rdata;
  logic             io_rdata_valid;
  logic             io_claim;
  logic             config_mode;
  logic             alt_mode;
  logic [11:0][7:0] regs;
  logic [7:0]       rdat;
  logic             rv;
  int               n_errors = 0;
  int               tests_run = 0;
  logic [7:0]       dflt [12] = '{8'h3B, 8'h9F, 8'hDC, 8'h78, 8'h00, 8'h00,
                                  8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Writes to identity, reserved and test slots must not stick
  row_s             rows [8] = '{'{4'h0, 8'h3F, 8'h3F}, '{4'h2, 8'hA5, 8'hA5},
                                 '{4'hA, 8'h5C, 8'h5C}, '{4'hD, 8'h12, ID},
                                 '{4'hE, 8'h77, REV},   '{4'hB, 8'hFF, 8'h00},
                                 '{4'hF, 8'hAB, 8'h00}, '{4'hC, 8'h11, 8'h00}};

  `define CHK(n, e, a) tests_run++; if ((a) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, a); n_errors++; end

  // 50 MHz clock
  always #10 clk = ~clk;

  io_host u_io_host (.clk(clk), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
                     .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));

  config_mode_register_access #(.ALT_KEY_VARIANT(1'b0), .ID_CODE(ID), .REV_CODE(REV))
    u_config_mode_register_access (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .io_claim(io_claim),
    .config_mode(config_mode), .configuration_registers(regs));

  // Second variant shares the host bus; only its mode is watched
  config_mode_register_access #(.ALT_KEY_VARIANT(1'b1), .ID_CODE(ID), .REV_CODE(REV))
    u_alt (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(), .io_rdata_valid(), .io_claim(),
    .config_mode(alt_mode), .configuration_registers());

  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog, far beyond the under one hundred cycles the run needs
  initial begin
    #200us;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      `CHK("default", dflt[i], regs[i])
    end
    u_io_host.unlock(`CFG_KEY_MAIN);
    `CHK("mode in", 1'b1, config_mode)
    // Claim is looked at mid-cycle while the read stands
    fork
      u_io_host.rd(`CFG_PORT_DATA, rdat, rv);
      begin
        @(negedge clk);
        #1;
        `CHK("claim in", 1'b1, io_claim)
      end
    join
    `CHK("no index", 1'b0, rv)
    u_io_host.wr(`CFG_PORT_DATA, 8'hEE);
    `CHK("no index wr", 8'h3B, regs[0])
    // Ordinary register traffic
    foreach (rows[k]) begin
      u_io_host.sel(rows[k].idx);
      u_io_host.wr(`CFG_PORT_DATA, rows[k].wd);
      u_io_host.rd(`CFG_PORT_DATA, rdat, rv);
      `CHK("rd valid", 1'b1, rv)
      `CHK("rd data", rows[k].exp, rdat)
    end
    `CHK("reg2", 8'hA5, regs[2])
    // Out-of-range index write is ignored
    u_io_host.sel(4'h2);
    u_io_host.wr(`CFG_PORT_INDEX, `CFG_KEY_MAIN);
    u_io_host.rd(`CFG_PORT_DATA, rdat, rv);
    `CHK("bad index", 8'hA5, rdat)
    u_io_host.leave();
    `CHK("mode out", 1'b0, config_mode)
    // Outside the mode the data port changes nothing
    u_io_host.wr(`CFG_PORT_DATA, 8'h00);
    fork
      u_io_host.rd(`CFG_PORT_DATA, rdat, rv);
      begin
        @(negedge clk);
        #1;
        `CHK("claim out", 1'b0, io_claim)
      end
    join
    `CHK("out rd", 1'b0, rv)
    `CHK("out reg0", 8'h3F, regs[0])
    // Foreign write between the keys aborts the unlock
    u_io_host.wr(`CFG_PORT_INDEX, `CFG_KEY_MAIN);
    u_io_host.wr(10'h2F8, 8'h00);
    u_io_host.wr(`CFG_PORT_INDEX, `CFG_KEY_MAIN);
    `CHK("abort", 1'b0, config_mode)
    // Variant key opens only the variant
    u_io_host.unlock(`CFG_KEY_ALT);
    `CHK("alt in", 1'b1, alt_mode)
    `CHK("main out", 1'b0, config_mode)
    u_io_host.leave();
    `CHK("alt out", 1'b0, alt_mode)
    // Ordinary reset keeps register contents
    u_io_host.unlock(`CFG_KEY_MAIN);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    `CHK("rst mode", 1'b0, config_mode)
    `CHK("rst reg0", 8'h3F, regs[0])
    `CHK("rst regA", 8'h5C, regs[10])
    final_report();
  end
endmodule
